/* design/hmt_mode_trigger.v */
// mode, trigger-pin and reporting configuration of a haptic driver
// assumes an i2c engine on clk_i delivers decoded register reads/writes and received addresses
// Overview of operation
// - with broadcast enabled the device also acknowledges the fixed shared address 0x58.
// - with averaging enabled the reported period is the mean of the last four, history zeroed.
// - with averaging disabled (reset) the reported period is the last single measurement.
// - compensation codes 0..3 scale drive up by 0%, 2%, 4%, 5%; reset code is 0.
// - changing the trigger pin function during a process aborts it into standby.
// - in pulse-trigger function a pin pulse starts a process and the launch bit starts or cancels.
// - in level-trigger function the pin level enables processes and the launch bit is ignored.
// - in interrupt function the pin is an open-drain interrupt and only the launch bit acts.
// - changing the mode field during a process puts the device straight into standby.
// - mode 0 is realtime playback, 1 sequencer, 2 diagnostics, 3 level calibration; reset 0.
// - a set mask bit keeps its status condition off the interrupt output.
// - the ten-bit period report counts in steps of 24.39 us.
`timescale 1ns/1ns
`include "hmt_regs.vh"
module hmt_mode_trigger #(
  parameter [6:0] OWN_ADDR = 7'h5A, // arbitrary default own address
  parameter DRIVE_W = 8
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // register access from the serial engine
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  output reg [7:0] reg_rdata_o,
  // serial address match
  input wire [6:0] rx_addr_i,
  input wire rx_addr_valid_i,
  output reg addr_ack_o,
  // trigger_interrupt_pin
  input wire trigger_interrupt_pin_i,
  output reg trigger_interrupt_pin_o,
  output reg trigger_interrupt_pin_oe_o,
  // playback engine
  input wire process_done_i,
  input wire overcurrent_flag_i,
  input wire overtemp_flag_i,
  input wire undervoltage_flag_i,
  input wire period_valid_i,
  input wire [9:0] period_i,
  input wire [DRIVE_W-1:0] drive_i,
  output reg process_start_o,
  output reg process_cancel_o,
  output reg standby_o,
  output reg process_busy_o,
  output reg [1:0] mode_o,
  output reg [DRIVE_W-1:0] drive_o
);
  // one-hot process states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  reg [7:0] cfg_reg;
  reg [3:0] mask_reg;
  reg [3:0] status_reg;
  reg [5:0] period_rsvd_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg pin_prev_reg;
  reg [2:0] comp_pct;
  reg start_req;
  reg cancel_req;
  reg abort_req;

  wire pin_sync;
  wire [9:0] period_report;
  wire [1:0] pin_func;
  wire [1:0] cfg_mode;
  wire cfg_wr;
  wire [DRIVE_W+2:0] drive_prod;
  wire [DRIVE_W+2:0] drive_sum;
  wire [3:0] status_set;
  wire int_pending;
  wire pin_rise;
  wire pin_fall;
  wire launch_wr;
  wire busy;

  assign pin_func = cfg_reg[`HMT_PIN_MSB:`HMT_PIN_LSB];
  assign cfg_mode = cfg_reg[`HMT_MODE_MSB:`HMT_MODE_LSB];
  assign cfg_wr = reg_we_i && (reg_addr_i == `HMT_OFS_MODE_TRIG);
  assign launch_wr = reg_we_i && (reg_addr_i == `HMT_OFS_LAUNCH);
  assign busy = state_reg[1];

  hmt_sync2 u_pin_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .async_i(trigger_interrupt_pin_i),
    .sync_o(pin_sync)
  );

  hmt_period_avg #(
    .W(10)
  ) u_period (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .period_valid_i(period_valid_i),
    .period_i(period_i),
    .avg_dis_i(cfg_reg[`HMT_AVG_DIS_BIT]),
    .report_o(period_report)
  );

  // edges are taken from the second synchroniser stage only
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_sync;
    end
  end

  assign pin_rise = pin_sync && !pin_prev_reg;
  assign pin_fall = !pin_sync && pin_prev_reg;

  // configuration register writes
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_reg <= `HMT_MODE_TRIG_RST;
      mask_reg <= `HMT_INT_MASK_RST;
      period_rsvd_reg <= 6'h00;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        `HMT_OFS_MODE_TRIG: cfg_reg <= reg_wdata_i;
        `HMT_OFS_INT_MASK: mask_reg <= reg_wdata_i[3:0];
        `HMT_OFS_PERIOD_HI: period_rsvd_reg <= reg_wdata_i[7:2];
        default: cfg_reg <= cfg_reg;
      endcase
    end
  end

  // a changed mode or pin function while running forces standby
  always @* begin
    abort_req = 1'b0;
    if (busy && cfg_wr) begin
      if (reg_wdata_i[`HMT_PIN_MSB:`HMT_PIN_LSB] != pin_func) begin
        abort_req = 1'b1;
      end
      if (reg_wdata_i[`HMT_MODE_MSB:`HMT_MODE_LSB] != cfg_mode) begin
        abort_req = 1'b1;
      end
    end
  end

  // start and cancel sources depend on the pin function
  always @* begin
    start_req = 1'b0;
    cancel_req = 1'b0;
    case (pin_func)
      `HMT_PIN_PULSE: begin
        start_req = pin_rise || (launch_wr && reg_wdata_i[0]);
        cancel_req = launch_wr && !reg_wdata_i[0];
      end
      `HMT_PIN_LEVEL: begin
        // the launch bit is ignored here; the pin level owns the process
        start_req = pin_rise;
        cancel_req = pin_fall;
      end
      `HMT_PIN_INTR: begin
        start_req = launch_wr && reg_wdata_i[0];
        cancel_req = launch_wr && !reg_wdata_i[0];
      end
      default: begin
        start_req = 1'b0;
        cancel_req = 1'b0;
      end
    endcase
  end

  always @* begin
    case (state_reg)
      ST_IDLE: begin
        state_next = (start_req && !cfg_wr) ? ST_RUN : ST_IDLE;
      end
      ST_RUN: begin
        if (abort_req || cancel_req || process_done_i) begin
          state_next = ST_IDLE;
        end else begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_IDLE;
      process_start_o <= 1'b0;
      process_cancel_o <= 1'b0;
      standby_o <= 1'b0;
      process_busy_o <= 1'b0;
      mode_o <= `HMT_MODE_PLAYBACK;
    end else begin
      state_reg <= state_next;
      process_start_o <= state_reg[0] && state_next[1];
      process_cancel_o <= busy && cancel_req && !abort_req;
      standby_o <= abort_req;
      process_busy_o <= state_next[1];
      mode_o <= cfg_wr ? reg_wdata_i[`HMT_MODE_MSB:`HMT_MODE_LSB] : cfg_mode;
    end
  end

  // status flags are sticky; a read clears them but a new event in that cycle wins
  assign status_set[`HMT_ST_OVERCURRENT] = overcurrent_flag_i;
  assign status_set[`HMT_ST_OVERTEMP] = overtemp_flag_i;
  assign status_set[`HMT_ST_UNDERVOLT] = undervoltage_flag_i;
  assign status_set[`HMT_ST_DONE] = busy && process_done_i;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_reg <= 4'h0;
    end else if (reg_re_i && reg_addr_i == `HMT_OFS_STATUS) begin
      status_reg <= status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  assign int_pending = |(status_reg & ~mask_reg);

  // open-drain: only ever pulls low, and only in interrupt function
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trigger_interrupt_pin_o <= 1'b0;
      trigger_interrupt_pin_oe_o <= 1'b0;
    end else begin
      trigger_interrupt_pin_o <= 1'b0;
      trigger_interrupt_pin_oe_o <= (pin_func == `HMT_PIN_INTR) && int_pending;
    end
  end

  // own and broadcast address acknowledge
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_ack_o <= 1'b0;
    end else begin
      addr_ack_o <= rx_addr_valid_i && ((rx_addr_i == OWN_ADDR) ||
        (cfg_reg[`HMT_BCAST_BIT] && rx_addr_i == `HMT_BCAST_ADDR));
    end
  end

  // supply-regulation compensation
  always @* begin
    case (cfg_reg[`HMT_COMP_MSB:`HMT_COMP_LSB])
      2'h0: comp_pct = `HMT_COMP_PCT0;
      2'h1: comp_pct = `HMT_COMP_PCT1;
      2'h2: comp_pct = `HMT_COMP_PCT2;
      2'h3: comp_pct = `HMT_COMP_PCT3;
      default: comp_pct = `HMT_COMP_PCT0;
    endcase
  end

  // truncating division keeps the boost at or below the nominal percentage
  assign drive_prod = ({3'b000, drive_i} * {{DRIVE_W{1'b0}}, comp_pct}) / `HMT_PCT_DIV;
  assign drive_sum = {3'b000, drive_i} + drive_prod;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drive_o <= {DRIVE_W{1'b0}};
    end else if (|drive_sum[DRIVE_W+2:DRIVE_W]) begin
      drive_o <= {DRIVE_W{1'b1}}; // saturate rather than wrap
    end else begin
      drive_o <= drive_sum[DRIVE_W-1:0];
    end
  end

  // register read-back; period counts are 24.39 us steps
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `HMT_OFS_STATUS: reg_rdata_o <= {4'h0, status_reg};
        `HMT_OFS_INT_MASK: reg_rdata_o <= {4'h0, mask_reg};
        `HMT_OFS_PERIOD_HI: reg_rdata_o <= {period_rsvd_reg, period_report[9:8]};
        `HMT_OFS_PERIOD_LO: reg_rdata_o <= period_report[7:0];
        `HMT_OFS_MODE_TRIG: reg_rdata_o <= cfg_reg;
        `HMT_OFS_LAUNCH: reg_rdata_o <= {7'h00, busy};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule

/* common/hmt_regs.vh */
// register map, field positions, reset values and timing figures of the mode/trigger block
// included by the hmt_mode_trigger design only; holds definitions only
`ifndef HMT_REGS_VH
`define HMT_REGS_VH

// register offsets
`define HMT_OFS_STATUS 8'h01
`define HMT_OFS_INT_MASK 8'h02
`define HMT_OFS_PERIOD_HI 8'h05
`define HMT_OFS_PERIOD_LO 8'h06
`define HMT_OFS_MODE_TRIG 8'h07
`define HMT_OFS_LAUNCH 8'h0C

// mode_trigger_config fields
`define HMT_BCAST_BIT 7
`define HMT_AVG_DIS_BIT 6
`define HMT_COMP_MSB 5
`define HMT_COMP_LSB 4
`define HMT_PIN_MSB 3
`define HMT_PIN_LSB 2
`define HMT_MODE_MSB 1
`define HMT_MODE_LSB 0
`define HMT_MODE_TRIG_RST 8'h44

// operating modes
`define HMT_MODE_PLAYBACK 2'h0
`define HMT_MODE_SEQUENCER 2'h1
`define HMT_MODE_DIAG 2'h2
`define HMT_MODE_CALIB 2'h3

// trigger pin functions
`define HMT_PIN_PULSE 2'h0
`define HMT_PIN_LEVEL 2'h1
`define HMT_PIN_INTR 2'h2
`define HMT_PIN_RSVD 2'h3

// status / mask bit positions
`define HMT_ST_OVERCURRENT 0
`define HMT_ST_OVERTEMP 1
`define HMT_ST_UNDERVOLT 2
`define HMT_ST_DONE 3
`define HMT_INT_MASK_RST 4'h0

// fixed broadcast peripheral address
`define HMT_BCAST_ADDR 7'h58

// compensation percentages per code
`define HMT_COMP_PCT0 3'h0
`define HMT_COMP_PCT1 3'h2
`define HMT_COMP_PCT2 3'h4
`define HMT_COMP_PCT3 3'h5
`define HMT_PCT_DIV 11'h064

// period step, hundredths of a microsecond per count
`define HMT_PERIOD_STEP_CUS 2439
`define HMT_AVG_DEPTH 4

`endif

/* design/hmt_sync2.v */
// two-flop synchroniser for a level arriving from outside the clock domain
// assumes the input is a plain level; no pulse shorter than two clocks is promised to pass
`timescale 1ns/1ns
module hmt_sync2 (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // level
  input wire async_i,
  output wire sync_o
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule

/* design/hmt_period_avg.v */
// resonance period history: last value or mean of the last four
// assumes one-cycle valid strobes from the same clock domain
`timescale 1ns/1ns
module hmt_period_avg #(
  parameter W = 10
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // measured periods
  input wire period_valid_i,
  input wire [W-1:0] period_i,
  input wire avg_dis_i,
  // reported period
  output reg [W-1:0] report_o
);
  reg [W-1:0] hist_reg [0:3];
  wire [W+1:0] sum;
  integer i;

  assign sum = {2'b00, hist_reg[0]} + {2'b00, hist_reg[1]}
             + {2'b00, hist_reg[2]} + {2'b00, hist_reg[3]};

  // history starts out all zero, so early averages read low
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        hist_reg[i] <= {W{1'b0}};
      end
    end else if (period_valid_i) begin
      hist_reg[0] <= period_i;
      for (i = 1; i < 4; i = i + 1) begin
        hist_reg[i] <= hist_reg[i-1];
      end
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      report_o <= {W{1'b0}};
    end else if (avg_dis_i) begin
      report_o <= hist_reg[0];
    end else begin
      report_o <= sum[W+1:2];
    end
  end
endmodule

/* tb/hmt_mode_trigger_properties.sv */
// port-level assertions for the mode/trigger configuration block
// bound into hmt_mode_trigger; shadows the config register from the write strobe
`timescale 1ns/1ns
module hmt_mt_props #(
  parameter [6:0] OWN_ADDR = 7'h5A,
  parameter DRIVE_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // register and address side
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic [6:0] rx_addr_i,
  input wire logic rx_addr_valid_i,
  input wire logic addr_ack_o,
  // pin and engine side
  input wire logic trigger_interrupt_pin_o,
  input wire logic trigger_interrupt_pin_oe_o,
  input wire logic [DRIVE_W-1:0] drive_i,
  input wire logic process_start_o,
  input wire logic standby_o,
  input wire logic process_busy_o,
  input wire logic [1:0] mode_o,
  input wire logic [DRIVE_W-1:0] drive_o
);
  logic [7:0] cfg_sh;
  logic [7:0] pct;
  logic [DRIVE_W+7:0] dexp;
  logic [DRIVE_W-1:0] dsat;
  wire cfg_wr = reg_we_i && reg_addr_i == 8'h07;
  wire go_wr = reg_we_i && reg_addr_i == 8'h0C && reg_wdata_i[0];
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i) cfg_sh <= 8'h44;
    else if (cfg_wr) cfg_sh <= reg_wdata_i;
  // truncating scale, saturating at full scale
  always_comb begin
    pct = (cfg_sh[5:4] == 2'h3) ? 8'h05 : {5'h00, cfg_sh[5:4], 1'b0};
    dexp = drive_i * (8'h64 + pct) / 8'h64;
    dsat = (dexp[DRIVE_W+7:DRIVE_W] != 8'h00) ? {DRIVE_W{1'b1}} : dexp[DRIVE_W-1:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_BCAST_ACK:
    assert property (rx_addr_valid_i |=> addr_ack_o == ($past(rx_addr_i) == OWN_ADDR
      || ($past(cfg_sh[7]) && $past(rx_addr_i) == 7'h58))) else $error("ack wrong");
  AST_COMP_DRIVE:
    assert property (1'b1 |=> drive_o == $past(dsat)) else $error("drive scale wrong");
  AST_MODE_FIELD:
    assert property (cfg_wr |=> mode_o == $past(reg_wdata_i[1:0])) else $error("mode wrong");
  AST_MODE_ABORT:
    assert property (cfg_wr && process_busy_o && reg_wdata_i[1:0] != mode_o
      |=> standby_o && !process_busy_o) else $error("mode change kept running");
  AST_PIN_ABORT:
    assert property (cfg_wr && process_busy_o && reg_wdata_i[3:2] != cfg_sh[3:2]
      |=> standby_o ##1 !standby_o) else $error("pin change kept running");
  AST_PULSE_LAUNCH:
    assert property (go_wr && cfg_sh[3:2] == 2'h0 && !process_busy_o
      |=> process_start_o && process_busy_o) else $error("launch ignored");
  AST_LEVEL_NO_LAUNCH:
    assert property (go_wr && cfg_sh[3:2] == 2'h1 && !process_busy_o
      |=> !process_start_o) else $error("launch acted in level function");
  AST_INTR_ONLY:
    assert property (cfg_sh[3:2] != 2'h2 && $past(cfg_sh[3:2]) != 2'h2
      |-> !trigger_interrupt_pin_oe_o && !trigger_interrupt_pin_o) else $error("pin driven");
  cover property (standby_o);
  cover property (addr_ack_o);
  cover property (trigger_interrupt_pin_oe_o);
endmodule
bind hmt_mode_trigger hmt_mt_props #(.OWN_ADDR(OWN_ADDR), .DRIVE_W(DRIVE_W)) props (
  .clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .rx_addr_i, .rx_addr_valid_i,
  .addr_ack_o, .trigger_interrupt_pin_o, .trigger_interrupt_pin_oe_o, .drive_i,
  .process_start_o, .standby_o, .process_busy_o, .mode_o, .drive_o);

/* tb/hmt_far_end.sv */
// external trigger source and pulled-up trigger/interrupt wire
// assumes the block pulls the wire low through its enable
`timescale 1ns/1ns
module hmt_far_end (
  // clock and pin
  input wire logic clk_i,
  input wire logic oe_i,
  output wire logic pin_o
);
  logic src_en = 1'b1;
  logic src_lvl = 1'b0;
  // released wire floats up to the pull-up level
  assign pin_o = oe_i ? 1'b0 : (src_en ? src_lvl : 1'b1);
  task automatic drive(input logic en, input logic lvl);
    @(negedge clk_i);
    src_en = en;
    src_lvl = lvl;
  endtask
  // held four clocks so the synchroniser cannot miss it
  task automatic pulse;
    drive(1'b1, 1'b1);
    repeat (3) @(negedge clk_i);
    drive(1'b1, 1'b0);
  endtask
endmodule

/* tb/haptic_mode_trigger_config_bench.sv */
// self-checking bench for the mode/trigger configuration block
// register strobes come straight from the bench; the far end owns the pin
`timescale 1ns/1ns
module haptic_mode_trigger_config_bench;
  logic clk_i = 1'b0, arst_n_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
  logic rx_addr_valid_i = 1'b0, process_done_i = 1'b0, overcurrent_flag_i = 1'b0;
  logic period_valid_i = 1'b0, overtemp_flag_i = 1'b0, undervoltage_flag_i = 1'b0;
  logic [6:0] rx_addr_i = 7'h00;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, drive_i = 8'hC8, v, h;
  logic [9:0] period_i = 10'h000;
  wire [7:0] reg_rdata_o, drive_o;
  wire [1:0] mode_o;
  wire addr_ack_o, trigger_interrupt_pin_o, trigger_interrupt_pin_oe_o, pin_w;
  wire process_start_o, process_cancel_o, standby_o, process_busy_o;
  int errors = 0, samples_checked = 0, cycles = 0;
  int pct[4] = '{0, 2, 4, 5};
  hmt_mode_trigger DUT (.clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .rx_addr_i, .rx_addr_valid_i, .addr_ack_o,
    .trigger_interrupt_pin_i(pin_w), .trigger_interrupt_pin_o, .trigger_interrupt_pin_oe_o,
    .process_done_i, .overcurrent_flag_i, .overtemp_flag_i,
    .undervoltage_flag_i, .period_valid_i, .period_i, .drive_i, .process_start_o,
    .process_cancel_o, .standby_o, .process_busy_o, .mode_o, .drive_o);
  hmt_far_end far (.clk_i, .oe_i(trigger_interrupt_pin_oe_o), .pin_o(pin_w));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_we_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_we_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_re_i = 1'b1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_re_i = 1'b0;
    d = reg_rdata_o;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [9:0] e);
    rd(a, v);
    chk(n, e, {2'b00, v});
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  task automatic per(input logic [9:0] p, input logic [9:0] e);
    period_i = p;
    pulse(period_valid_i);
    repeat (2) @(negedge clk_i);
    rd(8'h05, h);
    rd(8'h06, v);
    chk("period", e, {h[1:0], v});
  endtask
  task automatic ack(input logic [6:0] a, input logic e);
    rx_addr_i = a;
    pulse(rx_addr_valid_i);
    chk("ack", {9'h000, e}, {9'h000, addr_ack_o});
  endtask
  task automatic t_period;
    wr(8'h07, 8'h04);
    per(10'h028, 10'h00A);
    per(10'h050, 10'h01E);
    per(10'h078, 10'h03C);
    per(10'h0A0, 10'h064);
    wr(8'h07, 8'h44);
    per(10'h3FF, 10'h3FF);
    $display("t_period done");
  endtask
  task automatic t_cfg;
    for (int i = 0; i < 4; i++) begin
      wr(8'h07, 8'h44 | (i[7:0] * 8'h11));
      chk("mode", i[9:0], {8'h00, mode_o});
      @(negedge clk_i);
      chk("drive", 10'(200 * (100 + pct[i]) / 100), {2'b00, drive_o});
    end
    rdchk("config", 8'h07, 10'h077);
    rdchk("unmapped", 8'h0F, 10'h000);
    wr(8'h07, 8'h44);
    $display("t_cfg done");
  endtask
  task automatic t_bcast;
    ack(7'h58, 1'b0);
    wr(8'h07, 8'hC4);
    ack(7'h58, 1'b1);
    ack(7'h5A, 1'b1);
    ack(7'h59, 1'b0);
    $display("t_bcast done");
  endtask
  task automatic t_pulse;
    wr(8'h07, 8'h40);
    wr(8'h0C, 8'h01);
    chk("start", 10'h001, {9'h000, process_start_o});
    wr(8'h0C, 8'h00);
    chk("cancel", 10'h001, {9'h000, process_cancel_o});
    far.pulse();
    repeat (4) @(negedge clk_i);
    chk("busy", 10'h001, {9'h000, process_busy_o});
    pulse(process_done_i);
    chk("busy", 10'h000, {9'h000, process_busy_o});
    $display("t_pulse done");
  endtask
  task automatic t_level;
    wr(8'h07, 8'h44);
    wr(8'h0C, 8'h01);
    chk("start", 10'h000, {9'h000, process_start_o});
    far.drive(1'b1, 1'b1);
    repeat (6) @(negedge clk_i);
    chk("busy", 10'h001, {9'h000, process_busy_o});
    far.drive(1'b1, 1'b0);
    repeat (6) @(negedge clk_i);
    chk("busy", 10'h000, {9'h000, process_busy_o});
    // reserved pin function must start nothing, from the launch bit or the pin
    wr(8'h07, 8'h4C);
    wr(8'h0C, 8'h01);
    chk("start", 10'h000, {9'h000, process_start_o});
    far.pulse();
    repeat (4) @(negedge clk_i);
    chk("busy", 10'h000, {9'h000, process_busy_o});
    $display("t_level done");
  endtask
  task automatic t_abort;
    wr(8'h07, 8'h40);
    wr(8'h0C, 8'h01);
    wr(8'h07, 8'h41);
    chk("standby", 10'h001, {9'h000, standby_o});
    chk("busy", 10'h000, {9'h000, process_busy_o});
    wr(8'h0C, 8'h01);
    wr(8'h07, 8'h45);
    chk("standby", 10'h001, {9'h000, standby_o});
    $display("t_abort done");
  endtask
  task automatic t_intr;
    wr(8'h07, 8'h48);
    far.drive(1'b0, 1'b0);
    wr(8'h0C, 8'h01);
    chk("busy", 10'h001, {9'h000, process_busy_o});
    pulse(process_done_i);
    repeat (2) @(negedge clk_i);
    chk("pin", 10'h000, {8'h00, pin_w, trigger_interrupt_pin_o});
    wr(8'h02, 8'h0F);
    rdchk("status", 8'h01, 10'h008);
    pulse(overcurrent_flag_i);
    repeat (2) @(negedge clk_i);
    chk("oe", 10'h000, {9'h000, trigger_interrupt_pin_oe_o});
    wr(8'h02, 8'h0E);
    repeat (2) @(negedge clk_i);
    chk("oe", 10'h001, {9'h000, trigger_interrupt_pin_oe_o});
    rdchk("status", 8'h01, 10'h001);
    pulse(overtemp_flag_i);
    pulse(undervoltage_flag_i);
    repeat (2) @(negedge clk_i);
    chk("oe", 10'h000, {9'h000, trigger_interrupt_pin_oe_o});
    wr(8'h02, 8'h0A);
    repeat (2) @(negedge clk_i);
    chk("oe", 10'h001, {9'h000, trigger_interrupt_pin_oe_o});
    rdchk("status", 8'h01, 10'h006);
    $display("t_intr done");
  endtask
  task automatic t_reset;
    rdchk("config", 8'h07, 10'h044);
    chk("mode", 10'h000, {8'h00, mode_o});
    rdchk("mask", 8'h02, 10'h000);
    chk("busy", 10'h000, {9'h000, process_busy_o});
    $display("t_reset done");
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    arst_n_i = 1'b1;
    t_reset();
    t_period();
    t_cfg();
    t_bcast();
    t_pulse();
    t_level();
    t_abort();
    t_intr();
    tally_and_finish();
  end
endmodule
